/* rtl/rscb_pkg.sv */
/*
  Constants, state type and timing figures of the reset source combiner.
  Assumes one 50 MHz system clock; all timing below except the start-up tick count (oscillator periods) is counted on it.
*/
package rscb_pkg;
  localparam int CLK_NS = 20;
  localparam int T_POR_NS = 10000;
  localparam int T_POWERUP_TIMER_MS = 64;
  localparam int T_RST_NS = 1000;
  localparam int T_FAILSAFE_CLOCK_MONITOR_NS = 2000;
  localparam int POR_CYC = (T_POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int POWERUP_TIMER_CYC = (T_POWERUP_TIMER_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int FAILSAFE_CLOCK_MONITOR_CYC = (T_FAILSAFE_CLOCK_MONITOR_NS + CLK_NS - 1) / CLK_NS;
  localparam int OST_TICKS = 1024;
  localparam int OST_W = 10;
  // Register indices on the register port.
  localparam logic [1:0] REG_CAUSE = 2'h0;
  localparam logic [1:0] REG_STATE = 2'h1;
  // Reset cause register layout.
  localparam int B_TRAP = 15;
  localparam int B_ILLOP = 14;
  localparam int B_CMIS = 9;
  localparam int B_PROGMEM_SLEEP_POWER = 8;
  localparam int B_PIN = 7;
  localparam int B_SOFT = 6;
  localparam int B_WDTEN = 5;
  localparam int B_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int B_SLEEP = 3;
  localparam int B_IDLE = 2;
  localparam int B_BOR = 1;
  localparam int B_POR = 0;
  localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;
  localparam logic [15:0] CAUSE_MASK = 16'hc3ff;
  localparam int CW2_OSC_LSB = 8;
  localparam int CURRENT_OSC_FIELD_LSB = 12;
  localparam int OSC_W = 3;
  typedef enum logic [1:0] {
    ST_POR = 2'h0,
    ST_HOLD = 2'h1,
    ST_DELAY = 2'h3,
    ST_RUN = 2'h2
  } rscb_state_e;
endpackage

/* rtl/rscb_timer.sv */
/*
  Down counter for reset and monitor delays.
  Assumes load is a pulse; busy is high until the loaded count has run out.
*/
`timescale 1ns/1ns
module rscb_timer #(
  parameter int W = 32
) (
  input wire logic clk, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic load, // Start a new delay.
  input wire logic [W-1:0] value, // Delay length in cycles.
  output logic busy // Delay still running.
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } rscb_tmr_s;
  rscb_tmr_s r;
  rscb_tmr_s next_r;

  // A reload restarts the delay even if one is running.
  always_comb begin
    next_r = r;
    if (load) begin
      next_r.cnt = value;
    end else if (r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign busy = (r.cnt != '0);
endmodule

/* rtl/rscb_ost.sv */
/*
  Oscillator start-up timer with PLL lock gate.
  Assumes osc_tick is a one-cycle pulse per oscillator period.
*/
`timescale 1ns/1ns
module rscb_ost (
  input wire logic clk, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic restart, // Begin a new start-up wait.
  input wire logic osc_tick, // One pulse per oscillator period.
  input wire logic pll_used, // PLL in the clock path.
  input wire logic pll_lock, // PLL reports lock.
  output logic clk_valid // Clock may be passed to the system.
);
  typedef struct packed {
    logic [rscb_pkg::OST_W-1:0] cnt;
    logic done;
  } rscb_ost_s;
  rscb_ost_s r;
  rscb_ost_s next_r;

  // Ten-bit count of oscillator periods; done after the last one.
  always_comb begin
    next_r = r;
    if (restart) begin
      next_r = '0;
    end else if (osc_tick && !r.done) begin
      next_r.cnt = r.cnt + 1'b1;
      if (r.cnt == rscb_pkg::OST_W'(rscb_pkg::OST_TICKS - 1)) begin
        next_r.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // A PLL clock is held back until lock is reported.
  assign clk_valid = r.done && (!pll_used || pll_lock);
endmodule

/* rtl/rscb_top.sv */
/*
  Reset source combiner: merges reset sources into the master system reset,
  keeps the reset cause register and chooses the clock after reset.
  Assumes RESETN is the power-on reset and all inputs are synchronous to CLK.
*/
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module rscb_top #(
  parameter int POWERUP_TIMER_CYCLES = rscb_pkg::POWERUP_TIMER_CYC
) (
  input wire logic CLK, // System clock, 50 MHz.
  input wire logic RESETN, // Power-on reset, active low.
  input wire logic [1:0] ADDR, // Register index.
  input wire logic [15:0] WDATA, // Write data.
  input wire logic WR, // Write strobe.
  input wire logic RD, // Read strobe.
  output logic [15:0] RDATA, // Read data, cycle after RD.
  input wire logic BROWNOUT, // Brown-out detector active.
  input wire logic MASTER_CLEAR_PIN, // External reset pin active.
  input wire logic SOFT_RESET_INSTR, // Reset instruction pulse.
  input wire logic WATCHDOG_TIMEOUT, // Watchdog time-out pulse.
  input wire logic CONFIG_MISMATCH, // Configuration mismatch pulse.
  input wire logic TRAP_CONFLICT, // Trap conflict pulse.
  input wire logic ILLEGAL_OP, // Illegal opcode or address mode pulse.
  input wire logic UNINIT_WREG_RESET, // Uninitialized register pointer pulse.
  input wire logic POWER_SAVE_SLEEP, // Power-save instruction, sleep.
  input wire logic POWER_SAVE_IDLE, // Power-save instruction, idle.
  input wire logic WATCHDOG_CLEAR_INSTR, // Watchdog clear pulse.
  input wire logic WATCHDOG_FUSE_ENABLE, // Watchdog fuse, one forces on.
  input wire logic IN_SLEEP, // Device currently asleep.
  input wire logic CLK_SWITCH_EN, // Clock switching enabled.
  input wire logic [15:0] CONFIG_WORD_TWO, // Configuration word two.
  input wire logic [15:0] OSC_CONTROL_REG, // Oscillator control register.
  input wire logic OSC_TICK, // One pulse per oscillator period.
  input wire logic PLL_USED, // PLL in the clock path.
  input wire logic PLL_LOCK, // PLL locked.
  input wire logic FAILSAFE_EN, // Fail-safe monitor enabled.
  output logic MASTER_SYSTEM_RESET, // Master reset, active high.
  output logic CPU_RUN, // Core may execute code.
  output logic [2:0] SYS_CLK_SELECT, // Clock source after reset.
  output logic WATCHDOG_RUN, // Watchdog running.
  output logic PMEM_BIAS_OFF, // Program memory bias off.
  output logic VREG_STANDBY, // Regulator in standby.
  output logic FAILSAFE_ACTIVE // Fail-safe monitor watching clock.
);
  typedef struct packed {
    logic [15:0] cause;
    rscb_pkg::rscb_state_e st;
    logic kind_por;
    logic kind_bor;
    logic [2:0] osc_sel;
    logic [15:0] rdata;
    logic failsafe_clock_monitor_armed;
  } rscb_top_s;
  rscb_top_s r;
  rscb_top_s next_r;

  logic src_any;
  logic cold_src;
  logic dly_load;
  logic [31:0] dly_value;
  logic dly_busy;
  logic clk_valid;
  logic failsafe_clock_monitor_busy;
  logic failsafe_clock_monitor_load;
  logic [15:0] hw_set;
  logic [15:0] hw_clr;

  // Any level or pulse source counts as an active reset request.
  assign src_any = BROWNOUT | MASTER_CLEAR_PIN | SOFT_RESET_INSTR
    | WATCHDOG_TIMEOUT | CONFIG_MISMATCH | TRAP_CONFLICT
    | ILLEGAL_OP | UNINIT_WREG_RESET;
  assign cold_src = BROWNOUT;

  // Hardware events that set or clear cause flags this cycle.
  always_comb begin
    hw_set = '0;
    hw_clr = '0;
    hw_set[rscb_pkg::B_TRAP] = TRAP_CONFLICT;
    hw_set[rscb_pkg::B_ILLOP] = ILLEGAL_OP | UNINIT_WREG_RESET;
    hw_set[rscb_pkg::B_CMIS] = CONFIG_MISMATCH;
    hw_set[rscb_pkg::B_PIN] = MASTER_CLEAR_PIN;
    hw_set[rscb_pkg::B_SOFT] = SOFT_RESET_INSTR;
    hw_set[rscb_pkg::B_WATCHDOG_TIMEOUT_FLAG] = WATCHDOG_TIMEOUT;
    hw_set[rscb_pkg::B_SLEEP] = POWER_SAVE_SLEEP;
    hw_set[rscb_pkg::B_IDLE] = POWER_SAVE_IDLE;
    hw_set[rscb_pkg::B_BOR] = BROWNOUT;
    hw_clr[rscb_pkg::B_WATCHDOG_TIMEOUT_FLAG] = POWER_SAVE_SLEEP | POWER_SAVE_IDLE
      | WATCHDOG_CLEAR_INSTR;
  end

  // Delay length depends on what kind of reset is ending.
  always_comb begin
    if (r.kind_por) begin
      dly_value = 32'(rscb_pkg::POR_CYC + POWERUP_TIMER_CYCLES + rscb_pkg::RST_CYC);
    end else if (r.kind_bor) begin
      dly_value = 32'(POWERUP_TIMER_CYCLES + rscb_pkg::RST_CYC);
    end else begin
      dly_value = 32'(rscb_pkg::RST_CYC);
    end
  end

  // Sequencer and register update. Hardware sets are applied after the
  // software write so a coinciding event is never lost.
  always_comb begin
    next_r = r;
    dly_load = 1'b0;
    next_r.rdata = '0;
    if (WR && ADDR == rscb_pkg::REG_CAUSE) begin
      next_r.cause = WDATA;
    end
    next_r.cause = (next_r.cause & ~hw_clr) | hw_set;
    next_r.cause = next_r.cause & rscb_pkg::CAUSE_MASK;
    if (cold_src) begin
      next_r.kind_bor = 1'b1;
    end
    case (r.st)
      rscb_pkg::ST_POR: begin
        next_r.st = src_any ? rscb_pkg::ST_HOLD : rscb_pkg::ST_DELAY;
        dly_load = !src_any;
      end
      rscb_pkg::ST_HOLD: begin
        if (!src_any) begin
          next_r.st = rscb_pkg::ST_DELAY;
          dly_load = 1'b1;
        end
      end
      rscb_pkg::ST_DELAY: begin
        if (src_any) begin
          next_r.st = rscb_pkg::ST_HOLD;
        end else if (!dly_busy) begin
          next_r.st = rscb_pkg::ST_RUN;
          next_r.kind_por = 1'b0;
          next_r.kind_bor = 1'b0;
        end
      end
      rscb_pkg::ST_RUN: begin
        if (src_any) begin
          next_r.st = rscb_pkg::ST_HOLD;
        end
      end
      default: begin
        next_r.st = rscb_pkg::ST_HOLD;
      end
    endcase
    // Clock choice is taken when the reset delay starts.
    if (dly_load) begin
      if (!CLK_SWITCH_EN || r.kind_por || r.kind_bor || cold_src) begin
        next_r.osc_sel = CONFIG_WORD_TWO[rscb_pkg::CW2_OSC_LSB +: rscb_pkg::OSC_W];
      end else begin
        next_r.osc_sel = OSC_CONTROL_REG[rscb_pkg::CURRENT_OSC_FIELD_LSB +: rscb_pkg::OSC_W];
      end
    end
    // Monitor arms once its own delay has run after release.
    if (r.st != rscb_pkg::ST_RUN || src_any) begin
      next_r.failsafe_clock_monitor_armed = 1'b0;
    end else if (!failsafe_clock_monitor_busy && !failsafe_clock_monitor_load) begin
      next_r.failsafe_clock_monitor_armed = FAILSAFE_EN;
    end
    if (RD) begin
      if (ADDR == rscb_pkg::REG_CAUSE) begin
        next_r.rdata = r.cause;
      end else if (ADDR == rscb_pkg::REG_STATE) begin
        next_r.rdata = {9'h000, r.failsafe_clock_monitor_armed, clk_valid, r.osc_sel, r.st};
      end
    end
  end

  // Power-on reset loads the cause register with its power-on value.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      r.cause <= rscb_pkg::CAUSE_POR_VAL;
      r.st <= rscb_pkg::ST_POR;
      r.kind_por <= 1'b1;
      r.kind_bor <= 1'b0;
      r.osc_sel <= 3'h0;
      r.rdata <= 16'h0000;
      r.failsafe_clock_monitor_armed <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // The monitor delay starts in the cycle the master reset releases. It is decoded from the
  // present state rather than from next_r, so the sequencer process never reads its own output.
  assign failsafe_clock_monitor_load = (r.st == rscb_pkg::ST_DELAY) && !src_any && !dly_busy;

  rscb_timer #(.W(32)) u_dly (
    .clk(CLK),
    .resetn(RESETN),
    .load(dly_load),
    .value(dly_value),
    .busy(dly_busy)
  );

  rscb_timer #(.W(16)) u_failsafe_clock_monitor (
    .clk(CLK),
    .resetn(RESETN),
    .load(failsafe_clock_monitor_load),
    .value(16'(rscb_pkg::FAILSAFE_CLOCK_MONITOR_CYC)),
    .busy(failsafe_clock_monitor_busy)
  );

  // Start-up wait restarts on cold resets and overlaps the reset delay.
  rscb_ost u_ost (
    .clk(CLK),
    .resetn(RESETN),
    .restart(cold_src),
    .osc_tick(OSC_TICK),
    .pll_used(PLL_USED),
    .pll_lock(PLL_LOCK),
    .clk_valid(clk_valid)
  );

  assign MASTER_SYSTEM_RESET = (r.st != rscb_pkg::ST_RUN) || src_any;
  assign CPU_RUN = !MASTER_SYSTEM_RESET && clk_valid;
  assign SYS_CLK_SELECT = r.osc_sel;
  assign WATCHDOG_RUN = WATCHDOG_FUSE_ENABLE | r.cause[rscb_pkg::B_WDTEN];
  // Bias stays up in sleep only while the power bit is one.
  assign PMEM_BIAS_OFF = IN_SLEEP && !r.cause[rscb_pkg::B_PROGMEM_SLEEP_POWER];
  assign VREG_STANDBY = IN_SLEEP && !r.cause[rscb_pkg::B_PROGMEM_SLEEP_POWER];
  assign FAILSAFE_ACTIVE = r.failsafe_clock_monitor_armed;
  assign RDATA = r.rdata;

  // Checks on the sequencer and the cause register.
  property p_src_hold;
    @(posedge CLK) disable iff (!RESETN) src_any |-> MASTER_SYSTEM_RESET ##1 MASTER_SYSTEM_RESET;
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("source active without reset");

  property p_pin_flag;
    @(posedge CLK) disable iff (!RESETN) MASTER_CLEAR_PIN |=> r.cause[7];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");

  property p_trap_flag;
    @(posedge CLK) disable iff (!RESETN) TRAP_CONFLICT |=> r.cause[15] && MASTER_SYSTEM_RESET;
  endproperty
  a_trap_flag: assert property (p_trap_flag) else $error("trap flag not set");

  property p_unimpl;
    @(posedge CLK) disable iff (!RESETN) RD |=> r.rdata[13:10] == 4'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits nonzero");

  property p_wdt_clr;
    @(posedge CLK) disable iff (!RESETN)
      WATCHDOG_CLEAR_INSTR && !WATCHDOG_TIMEOUT |=> !r.cause[4];
  endproperty
  a_wdt_clr: assert property (p_wdt_clr) else $error("timeout flag not cleared");

  property p_sw_write;
    @(posedge CLK) disable iff (!RESETN)
      WR && ADDR == 2'h0 && hw_set == 16'h0000 && hw_clr == 16'h0000
      |=> r.cause == ($past(WDATA) & 16'hc3ff);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("software write lost");

  property p_release;
    @(posedge CLK) disable iff (!RESETN)
      r.st == rscb_pkg::ST_DELAY && dly_busy |=> r.st != rscb_pkg::ST_RUN;
  endproperty
  a_release: assert property (p_release) else $error("released during delay");

  property p_cpu;
    @(posedge CLK) disable iff (!RESETN)
      CPU_RUN |-> u_ost.r.done && (!PLL_USED || PLL_LOCK) && r.st == rscb_pkg::ST_RUN && !src_any;
  endproperty
  a_cpu: assert property (p_cpu) else $error("core ran without clock");

  property p_failsafe_clock_monitor;
    @(posedge CLK) disable iff (!RESETN)
      $fell(MASTER_SYSTEM_RESET) |-> !FAILSAFE_ACTIVE [*8];
  endproperty
  a_failsafe_clock_monitor: assert property (p_failsafe_clock_monitor) else $error("monitor started early");

  property p_clk_fuse;
    @(posedge CLK) disable iff (!RESETN)
      dly_load && !CLK_SWITCH_EN |=> SYS_CLK_SELECT == $past(CONFIG_WORD_TWO[10:8]);
  endproperty
  a_clk_fuse: assert property (p_clk_fuse) else $error("wrong clock after reset");

  property p_set_wins;
    @(posedge CLK) disable iff (!RESETN)
      hw_set != 16'h0000 |=> (r.cause & $past(hw_set)) == $past(hw_set);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat hardware set");

  c_pin_reset: cover property (@(posedge CLK) MASTER_CLEAR_PIN ##1 !MASTER_CLEAR_PIN);
  c_release: cover property (@(posedge CLK) $fell(MASTER_SYSTEM_RESET));
  c_cpu_run: cover property (@(posedge CLK) $rose(CPU_RUN));
  c_failsafe_clock_monitor_on: cover property (@(posedge CLK) $rose(FAILSAFE_ACTIVE));
endmodule

/* tb/rscb_osc_model.sv */
/*
  Behavioural oscillator and PLL seen by the reset source combiner.
  Assumes the oscillator runs one period per system clock once power is good.
*/
`timescale 1ns/1ns
module rscb_osc_model #(
  parameter int LOCK_CYC = 200
) (
  input wire logic clk, // System clock.
  input wire logic resetn, // Power-on reset, active low.
  output logic osc_tick, // One pulse per oscillator period.
  output logic pll_lock // PLL locked.
);
  int cnt;
  // The oscillator stays quiet during power-on; lock comes 200 cycles after it starts, well before the 1024-period start-up count ends.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      osc_tick <= 1'b0;
      pll_lock <= 1'b0;
    end else begin
      osc_tick <= 1'b1;
      if (cnt < LOCK_CYC) begin
        cnt <= cnt + 1;
      end
      pll_lock <= (cnt >= LOCK_CYC);
    end
  end
endmodule

/* tb/rscb_top_test.sv */
/*
  Self-checking bench of the reset source combiner.
  Assumes a shortened power-up timer of 20 cycles and a 50 MHz clock.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin errors++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module rscb_top_test;
  logic clk = 1'b0, resetn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, fuse = 1'b0, in_sleep = 1'b0, sw_en = 1'b1, fs_en = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000, rdata, cfg2 = 16'h0500, oscc = 16'h3000, v;
  logic [10:0] ev = 11'h000;
  logic msr, cpu_run, wdr, pbo, vsb, fsa, tick, lock;
  logic [2:0] csel;
  int errors = 0, compares = 0, n;
  time rt;
  rscb_top #(.POWERUP_TIMER_CYCLES(20)) dut_u (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .BROWNOUT(ev[7]), .MASTER_CLEAR_PIN(ev[0]), .SOFT_RESET_INSTR(ev[1]),
    .WATCHDOG_TIMEOUT(ev[2]), .CONFIG_MISMATCH(ev[3]), .TRAP_CONFLICT(ev[4]), .ILLEGAL_OP(ev[5]),
    .UNINIT_WREG_RESET(ev[6]), .POWER_SAVE_SLEEP(ev[8]), .POWER_SAVE_IDLE(ev[9]), .WATCHDOG_CLEAR_INSTR(ev[10]),
    .WATCHDOG_FUSE_ENABLE(fuse), .IN_SLEEP(in_sleep), .CLK_SWITCH_EN(sw_en), .CONFIG_WORD_TWO(cfg2),
    .OSC_CONTROL_REG(oscc), .OSC_TICK(tick), .PLL_USED(1'b1), .PLL_LOCK(lock), .FAILSAFE_EN(fs_en),
    .MASTER_SYSTEM_RESET(msr), .CPU_RUN(cpu_run), .SYS_CLK_SELECT(csel), .WATCHDOG_RUN(wdr),
    .PMEM_BIAS_OFF(pbo), .VREG_STANDBY(vsb), .FAILSAFE_ACTIVE(fsa));
  rscb_osc_model osc_u (.clk(clk), .resetn(resetn), .osc_tick(tick), .pll_lock(lock));
  // Free-running system clock.
  always #10 clk = ~clk;
  // Prints the counts and the verdict, then stops.
  task test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A wait that ran out ends the run at once.
  task timed_out(input string what);
    errors++;
    $display("ERROR %s timed out", what);
    test_done;
  endtask
  // One write cycle on the register port.
  task wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  // One read cycle; the data are taken in the cycle after the strobe.
  task rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  // Counts cycles until the master reset falls.
  task wait_low(output int c);
    c = 0;
    while (msr !== 1'b0) begin
      @(posedge clk);
      #1 c++;
      if (c > 2000) timed_out("master reset");
    end
  endtask
  // Holds an event mask for a number of cycles.
  task drive(input logic [10:0] m, input int c);
    @(posedge clk);
    ev <= m;
    repeat (c) @(posedge clk);
    ev <= 11'h000;
  endtask
  // Cold start: delays, cause value, clock choice and the late start of the monitor and the core.
  task t_power_on;
    wait_low(n);
    `CHK("cold delay", 1'b1, (n >= 570 && n <= 575))
    `CHK("run at release", 1'b0, cpu_run)
    `CHK("monitor at release", 1'b0, fsa)
    `CHK("cold clock", 3'h5, csel)
    rd(2'h0, v);
    `CHK("cold cause", 16'h0003, v)
    repeat (90) @(posedge clk);
    #1 `CHK("monitor early", 1'b0, fsa)
    for (int i = 0; i < 40 && fsa !== 1'b1; i++) @(posedge clk);
    if (fsa !== 1'b1) timed_out("monitor");
    while (($time - rt) / 20 < 1000) @(posedge clk);
    #1 `CHK("run before start-up count", 1'b0, cpu_run)
    for (int i = 0; i < 120 && cpu_run !== 1'b1; i++) @(posedge clk);
    `CHK("start-up overlaps delay", 1'b1, cpu_run)
  endtask
  // Software access: any value, unimplemented bits, no reset from a write, unmapped index.
  task t_regs;
    wr(2'h0, 16'hffff);
    `CHK("reset after write", 1'b0, msr)
    rd(2'h0, v);
    `CHK("all ones", 16'hc3ff, v)
    rd(2'h2, v);
    `CHK("unmapped", 16'h0000, v)
    rd(2'h1, v);
    `CHK("state word", 16'h0076, v)
    wr(2'h0, 16'h0000);
    rd(2'h0, v);
    `CHK("all clear", 16'h0000, v)
  endtask
  // Each warm source holds the reset, sets its flag (the register pointer source sets the illegal opcode flag) and keeps the running clock.
  task t_sources;
    logic [15:0] exp_bits [7];
    exp_bits = '{16'h0080, 16'h0040, 16'h0010, 16'h0200, 16'h8000, 16'h4000, 16'h4000};
    for (int k = 0; k < 7; k++) begin
      wr(2'h0, 16'h0000);
      @(posedge clk);
      ev <= 11'h001 << k;
      #1 `CHK("held by source", 1'b1, msr)
      @(posedge clk);
      #1 `CHK("still held", 1'b1, msr)
      @(posedge clk);
      ev <= 11'h000;
      wait_low(n);
      `CHK("warm delay", 1'b1, (n >= 50 && n <= 54))
      rd(2'h0, v);
      `CHK("source flag", exp_bits[k], v)
      `CHK("warm clock", 3'h3, csel)
    end
  endtask
  // Brown-out takes the fuse clock; with switching off a pin reset does too.
  task t_brownout;
    wr(2'h0, 16'h0000);
    drive(11'h080, 1);
    wait_low(n);
    `CHK("brown-out delay", 1'b1, (n >= 70 && n <= 75))
    rd(2'h0, v);
    `CHK("brown-out flag", 16'h0002, v)
    `CHK("brown-out clock", 3'h5, csel)
    sw_en <= 1'b0;
    cfg2 <= 16'h0600;
    drive(11'h001, 1);
    wait_low(n);
    `CHK("fixed clock", 3'h6, csel)
    sw_en <= 1'b1;
  endtask
  // Power-save flags, watchdog flag clearing and set winning over a clear.
  task t_power_save;
    wr(2'h0, 16'h0010);
    drive(11'h400, 1);
    rd(2'h0, v);
    `CHK("clear instr", 16'h0000, v)
    wr(2'h0, 16'h0010);
    drive(11'h100, 1);
    rd(2'h0, v);
    `CHK("sleep entry", 16'h0008, v)
    wr(2'h0, 16'h0010);
    drive(11'h200, 1);
    rd(2'h0, v);
    `CHK("idle entry", 16'h0004, v)
    @(posedge clk);
    addr <= 2'h0;
    wdata <= 16'h0000;
    wr_s <= 1'b1;
    ev <= 11'h100;
    @(posedge clk);
    wr_s <= 1'b0;
    ev <= 11'h000;
    rd(2'h0, v);
    `CHK("set beats write", 16'h0008, v)
    wr(2'h0, 16'h0000);
    drive(11'h404, 1);
    wait_low(n);
    rd(2'h0, v);
    `CHK("timeout beats clear", 16'h0010, v)
  endtask
  // Watchdog enable and program memory power follow their bits.
  task t_outputs;
    fuse <= 1'b0;
    wr(2'h0, 16'h0020);
    `CHK("soft enable", 1'b1, wdr)
    wr(2'h0, 16'h0000);
    `CHK("watchdog off", 1'b0, wdr)
    fuse <= 1'b1;
    in_sleep <= 1'b1;
    @(posedge clk);
    #1 `CHK("fuse forces", 1'b1, wdr)
    `CHK("bias off", 2'b11, {pbo, vsb})
    wr(2'h0, 16'h0100);
    `CHK("bias kept", 2'b00, {pbo, vsb})
    in_sleep <= 1'b0;
    fuse <= 1'b0;
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rt = $time;
    t_power_on;
    t_regs;
    t_sources;
    t_brownout;
    t_power_save;
    t_outputs;
    test_done;
  end
endmodule
